// ---- pkg/pllpd_regs.svh ----
// Register offsets, field positions and reset values of the power and divider fields
`ifndef PLLPD_REGS_SVH
`define PLLPD_REGS_SVH
`define PLLPD_ADDR_W          15
`define PLLPD_OFF_PWR         15'h0002
`define PLLPD_OFF_DIV_LO      15'h0010
`define PLLPD_OFF_DIV_MID     15'h0011
`define PLLPD_OFF_DIV_HI      15'h0012
`define PLLPD_PWR_SEL_LSB     0
`define PLLPD_PWR_SEL_MSB     1
`define PLLPD_RST_BIT         2
`define PLLPD_DIVHI_MSB       1
`define PLLPD_DITH_LSB        2
`define PLLPD_DITH_MSB        3
`define PLLPD_ORD_LSB         4
`define PLLPD_ORD_MSB         6
`define PLLPD_PWR_SEL_RST     2'h0
`define PLLPD_DIV_RST         18'h00010
`define PLLPD_DIV_MIN         18'h00010
`define PLLPD_DIV_MAX         18'h3FFF4
`define PLLPD_DITH_RST        2'h0
`define PLLPD_ORD_RST         3'h0
`endif

// ---- pkg/pllpd_pkg.sv ----
// Types of the power and divider field bank
package pllpd_pkg;
	typedef enum logic [1:0]
	{
		PLLPD_PWR_OFF    = 2'h0,
		PLLPD_PWR_ON     = 2'h1,
		PLLPD_PWR_PIN    = 2'h2,
		PLLPD_PWR_RSVD   = 2'h3
	} pllpd_pwr_t;
	typedef enum logic [1:0]
	{
		PLLPD_DITH_WEAK   = 2'h0,
		PLLPD_DITH_MEDIUM = 2'h1,
		PLLPD_DITH_STRONG = 2'h2,
		PLLPD_DITH_NONE   = 2'h3
	} pllpd_dith_t;
	typedef enum logic [2:0]
	{
		PLLPD_ORD_INT  = 3'h0,
		PLLPD_ORD_1    = 3'h1,
		PLLPD_ORD_2    = 3'h2,
		PLLPD_ORD_3    = 3'h3,
		PLLPD_ORD_4    = 3'h4
	} pllpd_ord_t;
endpackage : pllpd_pkg

// ---- src/pllpd_sync.sv ----
// Two-flop synchroniser for the chip enable pin
`timescale 1ns/1ps
`default_nettype none
module pllpd_sync
(
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic ce,
	input  wire logic din,
	output var  logic dout
);
	typedef struct packed
	{
		logic meta;
		logic sync;
	} pllpd_sync_t;
	pllpd_sync_t s_q;
	pllpd_sync_t s_d;
	always_comb
	begin
		s_d = s_q;
		if (ce)
		begin
			s_d.meta = din;
			s_d.sync = s_q.meta;
		end
	end
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			s_q <= '0;
		else
			s_q <= s_d;
	end
	assign dout = s_q.sync;
endmodule : pllpd_sync
`default_nettype wire

// ---- src/pllpd_fields.sv ----
// Power state, software reset, feedback divider and modulator field bank
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "pllpd_regs.svh"
module pllpd_fields
(
	input  wire logic                       clk,
	input  wire logic                       resetn,
	input  wire logic                       ce,
	input  wire logic [`PLLPD_ADDR_W-1:0]   addr,
	input  wire logic [7:0]                 wdata,
	input  wire logic                       wr,
	input  wire logic                       rd,
	output var  logic [7:0]                 rdata,
	input  wire logic                       chip_enable_pin,
	input  wire logic                       ramp_enable,
	output var  logic                       powered_up,
	output var  logic                       ramp_start,
	output var  logic [17:0]                feedback_divide,
	output var  pllpd_pkg::pllpd_dith_t     dither_strength,
	output var  pllpd_pkg::pllpd_ord_t      modulator_order,
	output var  logic                       divide_out_of_range,
	output var  logic                       reserved_setting
);
	import pllpd_pkg::*;
	typedef struct packed
	{
		logic [1:0]  pwr_sel;
		logic [17:0] div;
		logic [1:0]  dith;
		logic [2:0]  ord;
		logic [7:0]  rdata;
		logic        ramp;
		logic        pwr;
	} pllpd_state_t;
	pllpd_state_t st_q;
	pllpd_state_t st_d;
	logic         ce_sync;
	logic [7:0]   rd_mux;
	pllpd_sync u_ce_sync
	(
		.clk    (clk),
		.resetn (resetn),
		.ce     (ce),
		.din    (chip_enable_pin),
		.dout   (ce_sync)
	);
	always_comb
	begin
		rd_mux = 8'h00;
		if (addr == `PLLPD_OFF_PWR)
			rd_mux = {6'h00, st_q.pwr_sel};
		else if (addr == `PLLPD_OFF_DIV_LO)
			rd_mux = st_q.div[7:0];
		else if (addr == `PLLPD_OFF_DIV_MID)
			rd_mux = st_q.div[15:8];
		else if (addr == `PLLPD_OFF_DIV_HI)
			rd_mux = {1'b0, st_q.ord, st_q.dith, st_q.div[17:16]};
	end
	always_comb
	begin
		st_d = st_q;
		st_d.ramp = 1'b0;
		if (rd)
			st_d.rdata = rd_mux;
		if (wr)
		begin
			if (addr == `PLLPD_OFF_PWR)
			begin
				if (wdata[`PLLPD_RST_BIT])
				begin
					// Bit self-clears; select, divider, dither and order return to defaults, read data is kept
					st_d.pwr_sel = `PLLPD_PWR_SEL_RST;
					st_d.div     = `PLLPD_DIV_RST;
					st_d.dith    = `PLLPD_DITH_RST;
					st_d.ord     = `PLLPD_ORD_RST;
				end
				else
					st_d.pwr_sel = wdata[`PLLPD_PWR_SEL_MSB:`PLLPD_PWR_SEL_LSB];
			end
			else if (addr == `PLLPD_OFF_DIV_LO)
			begin
				st_d.div[7:0] = wdata;
				st_d.ramp     = ramp_enable;
			end
			else if (addr == `PLLPD_OFF_DIV_MID)
				st_d.div[15:8] = wdata;
			else if (addr == `PLLPD_OFF_DIV_HI)
			begin
				st_d.div[17:16] = wdata[`PLLPD_DIVHI_MSB:0];
				st_d.dith       = wdata[`PLLPD_DITH_MSB:`PLLPD_DITH_LSB];
				st_d.ord        = wdata[`PLLPD_ORD_MSB:`PLLPD_ORD_LSB];
			end
		end
		// Reserved select keeps the part off, the safe choice
		case (pllpd_pwr_t'(st_d.pwr_sel))
			PLLPD_PWR_ON:  st_d.pwr = 1'b1;
			PLLPD_PWR_PIN: st_d.pwr = ce_sync;
			default:       st_d.pwr = 1'b0;
		endcase
	end
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			// Power-on defaults
			st_q.pwr_sel <= `PLLPD_PWR_SEL_RST;
			st_q.div     <= `PLLPD_DIV_RST;
			st_q.dith    <= `PLLPD_DITH_RST;
			st_q.ord     <= `PLLPD_ORD_RST;
			st_q.rdata   <= 8'h00;
			st_q.ramp    <= 1'b0;
			st_q.pwr     <= 1'b0;
		end
		else if (ce)
			st_q <= st_d;
	end
	assign rdata           = st_q.rdata;
	assign powered_up      = st_q.pwr;
	assign ramp_start      = st_q.ramp;
	assign feedback_divide = st_q.div;
	assign dither_strength = pllpd_dith_t'(st_q.dith);
	assign modulator_order = pllpd_ord_t'(st_q.ord);
	// Flag only; hardware does not clamp, software owns the range
	assign divide_out_of_range = (st_q.div < `PLLPD_DIV_MIN) || (st_q.div > `PLLPD_DIV_MAX);
	assign reserved_setting = (st_q.pwr_sel == 2'h3) || (st_q.ord > 3'h4);

	pwr_off_a: assert property (@(posedge clk) disable iff (!resetn)
		(ce && st_q.pwr_sel == 2'h0 && !(wr && addr == `PLLPD_OFF_PWR)) |=> !powered_up)
		else $error("powered up while select is off");
	pwr_on_a: assert property (@(posedge clk) disable iff (!resetn)
		(ce && st_q.pwr_sel == 2'h1 && !(wr && addr == `PLLPD_OFF_PWR)) |=> powered_up)
		else $error("not powered up while select is on");
	pwr_pin_a: assert property (@(posedge clk) disable iff (!resetn)
		(ce && st_q.pwr_sel == 2'h2 && !(wr && addr == `PLLPD_OFF_PWR))
		|=> powered_up == $past(ce_sync))
		else $error("power does not follow pin");
	soft_rst_a: assert property (@(posedge clk) disable iff (!resetn)
		(ce && wr && addr == `PLLPD_OFF_PWR && wdata[`PLLPD_RST_BIT])
		|=> (feedback_divide == `PLLPD_DIV_RST && st_q.pwr_sel == 2'h0
		&& st_q.dith == 2'h0 && st_q.ord == 3'h0))
		else $error("register reset did not restore defaults");
	div_lo_a: assert property (@(posedge clk) disable iff (!resetn)
		(ce && wr && addr == `PLLPD_OFF_DIV_LO) |=> feedback_divide[7:0] == $past(wdata))
		else $error("low divider byte not stored");
	div_hold_a: assert property (@(posedge clk) disable iff (!resetn)
		(!wr || !ce) |=> $stable(feedback_divide))
		else $error("divider changed without write");
	ramp_go_a: assert property (@(posedge clk) disable iff (!resetn)
		ce |=> ramp_start == $past(wr && addr == `PLLPD_OFF_DIV_LO && ramp_enable))
		else $error("ramp start mismatch");
	dith_wr_a: assert property (@(posedge clk) disable iff (!resetn)
		(ce && wr && addr == `PLLPD_OFF_DIV_HI)
		|=> (st_q.dith == $past(wdata[3:2]) && st_q.ord == $past(wdata[6:4])))
		else $error("dither or order not stored");
	rd_data_a: assert property (@(posedge clk) disable iff (!resetn)
		(ce && rd && addr == `PLLPD_OFF_DIV_MID && !wr) |=> rdata == $past(st_q.div[15:8]))
		else $error("mid divider read back wrong");
	ramp_c: cover property (@(posedge clk) disable iff (!resetn) ramp_start);
	pin_c: cover property (@(posedge clk) disable iff (!resetn)
		st_q.pwr_sel == 2'h2 && powered_up);
	srst_c: cover property (@(posedge clk) disable iff (!resetn)
		wr && addr == `PLLPD_OFF_PWR && wdata[`PLLPD_RST_BIT]);
endmodule : pllpd_fields
`default_nettype wire

// ---- verif/pllpd_fields_tb.sv ----
// Self-checking bench of the power and divider field bank
`timescale 1ns/1ps
`default_nettype none
`include "pllpd_regs.svh"
module pllpd_fields_tb;
	import pllpd_pkg::*;
	logic        clk = 0, resetn = 0, ce = 1, wr = 0, rd = 0, pin = 0, ramp_en = 0;
	logic [14:0] addr = '0;
	logic [7:0]  wdata = '0;
	logic [7:0]  rdata;
	logic        pwr, ramp, oor, rsv;
	logic [17:0] div;
	pllpd_dith_t dith;
	pllpd_ord_t  ord;
	int          errors = 0;
	int          n_tests = 0;
	pllpd_fields i_pllpd_fields (.clk(clk), .resetn(resetn), .ce(ce), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .chip_enable_pin(pin),
		.ramp_enable(ramp_en), .powered_up(pwr), .ramp_start(ramp), .feedback_divide(div),
		.dither_strength(dith), .modulator_order(ord), .divide_out_of_range(oor),
		.reserved_setting(rsv));
	initial forever #10 clk = ~clk;
	task chk(input string nm, input logic [17:0] exp, input logic [17:0] got);
		n_tests++;
		if (got !== exp)
		begin
			errors++;
			$display("BAD %s exp %0h got %0h", nm, exp, got);
		end
	endtask : chk
	// Strobe held one cycle, outputs read after the taking edge settles
	task wr_reg(input logic [14:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask : wr_reg
	task rd_chk(input logic [14:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk("rdata", exp, rdata);
	endtask : rd_chk
	task t_defaults;
		chk("div", `PLLPD_DIV_RST, div);
		chk("dith", `PLLPD_DITH_RST, dith);
		chk("ord", `PLLPD_ORD_RST, ord);
		chk("pwr", 0, pwr);
		rd_chk(`PLLPD_OFF_PWR, 8'h00);
		rd_chk(`PLLPD_OFF_DIV_LO, 8'h10);
		rd_chk(`PLLPD_OFF_DIV_HI, 8'h00);
		rd_chk(15'h0020, 8'h00);
	endtask : t_defaults
	task t_power;
		wr_reg(`PLLPD_OFF_PWR, 8'h01);
		chk("pwr on", 1, pwr);
		wr_reg(`PLLPD_OFF_PWR, 8'h02);
		repeat (4) @(posedge clk);
		#1 chk("pwr pin lo", 0, pwr);
		@(posedge clk);
		pin <= 1'b1;
		repeat (4) @(posedge clk);
		#1 chk("pwr pin hi", 1, pwr);
		wr_reg(`PLLPD_OFF_PWR, 8'h00);
		chk("pwr off", 0, pwr);
		wr_reg(`PLLPD_OFF_PWR, 8'h03);
		chk("pwr rsvd", 0, pwr);
		chk("rsv", 1, rsv);
	endtask : t_power
	task t_divider;
		wr_reg(`PLLPD_OFF_DIV_LO, 8'hF4);
		wr_reg(`PLLPD_OFF_DIV_MID, 8'hFF);
		wr_reg(`PLLPD_OFF_DIV_HI, 8'h03);
		chk("div max", `PLLPD_DIV_MAX, div);
		chk("oor max", 0, oor);
		rd_chk(`PLLPD_OFF_DIV_MID, 8'hFF);
		wr_reg(`PLLPD_OFF_DIV_LO, 8'hF5);
		chk("oor high", 1, oor);
		@(posedge clk);
		ce <= 1'b0;
		wr_reg(`PLLPD_OFF_DIV_HI, 8'h00);
		@(posedge clk);
		ce <= 1'b1;
		chk("div frozen", 18'h3FFF5, div);
		wr_reg(`PLLPD_OFF_DIV_HI, 8'h00);
		wr_reg(`PLLPD_OFF_DIV_MID, 8'h00);
		wr_reg(`PLLPD_OFF_DIV_LO, 8'h0F);
		chk("oor low", 1, oor);
	endtask : t_divider
	task t_ramp;
		@(posedge clk);
		ramp_en <= 1'b1;
		wr_reg(`PLLPD_OFF_DIV_MID, 8'h01);
		chk("ramp mid", 0, ramp);
		wr_reg(`PLLPD_OFF_DIV_LO, 8'h20);
		chk("ramp go", 1, ramp);
		@(posedge clk);
		#1 chk("ramp end", 0, ramp);
		@(posedge clk);
		ramp_en <= 1'b0;
		wr_reg(`PLLPD_OFF_DIV_LO, 8'h20);
		chk("ramp off", 0, ramp);
	endtask : t_ramp
	task t_modes;
		// Clear the reserved select left by the power scenario
		wr_reg(`PLLPD_OFF_PWR, 8'h00);
		chk("rsv clr", 0, rsv);
		for (int i = 0; i < 8; i++)
		begin
			wr_reg(`PLLPD_OFF_DIV_HI, {1'b0, i[2:0], i[1:0], 2'b01});
			chk("dith", i[1:0], dith);
			chk("ord", i[2:0], ord);
			chk("rsv", (i > 4), rsv);
			rd_chk(`PLLPD_OFF_DIV_HI, {1'b0, i[2:0], i[1:0], 2'b01});
		end
	endtask : t_modes
	task t_swreset;
		wr_reg(`PLLPD_OFF_PWR, 8'h01);
		wr_reg(`PLLPD_OFF_PWR, 8'h05);
		chk("div", `PLLPD_DIV_RST, div);
		chk("dith", `PLLPD_DITH_RST, dith);
		chk("ord", `PLLPD_ORD_RST, ord);
		chk("pwr", 0, pwr);
		rd_chk(`PLLPD_OFF_PWR, 8'h00);
	endtask : t_swreset
	task give_verdict;
		$display("errors %0d n_tests %0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : give_verdict
	initial
	begin
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		#1;
		t_defaults();
		t_power();
		t_divider();
		t_ramp();
		t_modes();
		t_swreset();
		give_verdict();
	end
	// Whole run is about a hundred cycles
	initial
	begin
		repeat (5000) @(posedge clk);
		errors++;
		give_verdict();
	end
endmodule : pllpd_fields_tb
`default_nettype wire
